// ---- rtl/rcrb_consts.svh ----
`ifndef RCRB_CONSTS_SVH
`define RCRB_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address is index * 4)
// ----------------------------------------
`define RCRB_IDX_SWITCHED  8'h35
`define RCRB_IDX_RAIL12    8'h36
`define RCRB_IDX_RAIL10    8'h37

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCRB_RST_SWITCHED  8'h0a
`define RCRB_RST_RAIL12    8'h3a
`define RCRB_RST_RAIL10    8'h1a

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define RCRB_MODE_LSB      0
`define RCRB_EXIT_LSB      2
`define RCRB_VSEL_LSB      4
`define RCRB_R12_LP_BIT    7
`define RCRB_R10_LP_LSB    6
`define RCRB_SW_WR_MASK    8'h0f

// ----------------------------------------
// Trim values, signed, in steps of 0.5 %
// ----------------------------------------
`define RCRB_R12_TRIM_TOP  8'sh06
`define RCRB_R12_LP_TRIM   8'shfa
`define RCRB_R10_TRIM_C0   8'sh0a
`define RCRB_R10_TRIM_C1   8'sh00
`define RCRB_R10_TRIM_C2   8'shfb
`define RCRB_R10_TRIM_C3   8'shf6
`define RCRB_R10_LP_BASE   8'shf6

`endif

// ---- rtl/rcrb_pkg.sv ----
package rcrb_pkg;

  // Converter operating class decoded from a two-bit mode field
  typedef enum logic [1:0] {
    RCRB_MODE_OFF,
    RCRB_MODE_AUTO,
    RCRB_MODE_PWM
  } rcrb_mode_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]        switchedReg;
    logic [7:0]        rail12Reg;
    logic [7:0]        rail10Reg;
    logic              standbyPrev;
    logic              ack;
    logic [31:0]       readData;
    logic              switchedOn;
    rcrb_mode_t        rail12Mode;
    rcrb_mode_t        rail10Mode;
    logic signed [7:0] rail12Trim;
    logic signed [7:0] rail10Trim;
    logic              rail12Low;
    logic              rail10Low;
  } rcrb_state_t;

  // Shared by both converter rails
  function automatic rcrb_mode_t modeClass(input logic [1:0] field);
    case (field)
      2'h0:    modeClass = RCRB_MODE_OFF;
      2'h3:    modeClass = RCRB_MODE_PWM;
      default: modeClass = RCRB_MODE_AUTO;
    endcase
  endfunction : modeClass

endpackage : rcrb_pkg

// ---- rtl/rcrb_rail_if.sv ----
`timescale 1ns/10ps

// Carries register fields to the set-point decoder and trims back
interface rcrb_rail_if;
  logic              standbyActive;
  logic [7:0]        rail12Reg;
  logic [7:0]        rail10Reg;
  logic signed [7:0] rail12Trim;
  logic signed [7:0] rail10Trim;
  logic              rail12Low;
  logic              rail10Low;

  modport ctrl (output standbyActive, rail12Reg, rail10Reg,
                input  rail12Trim, rail10Trim, rail12Low, rail10Low);
  modport dec  (input  standbyActive, rail12Reg, rail10Reg,
                output rail12Trim, rail10Trim, rail12Low, rail10Low);
endinterface : rcrb_rail_if

// ---- rtl/rcrb_trim_decode.sv ----
`timescale 1ns/10ps
`include "rcrb_consts.svh"

module rcrb_trim_decode (
  // Register fields in, set points out
  rcrb_rail_if.dec rails
);
  import rcrb_pkg::*;

  logic [2:0] r12Sel;
  logic [1:0] r10Sel;
  logic [1:0] r10Lp;

  // ----------------------------------------
  // Set-point selection
  // ----------------------------------------
  // Low-power points only apply while standby is held; release falls back
  always_comb begin
    r12Sel          = rails.rail12Reg[`RCRB_VSEL_LSB +: 3];
    r10Sel          = rails.rail10Reg[`RCRB_VSEL_LSB +: 2];
    r10Lp           = rails.rail10Reg[`RCRB_R10_LP_LSB +: 2];
    rails.rail12Low = rails.standbyActive && rails.rail12Reg[`RCRB_R12_LP_BIT]; // (R4) (R11)
    rails.rail10Low = rails.standbyActive && (r10Lp != 2'h0);                   // (R6) (R11)
    // Each code step is 1 %, i.e. two half-percent units
    rails.rail12Trim = `RCRB_R12_TRIM_TOP - 8'(signed'({4'h0, r12Sel, 1'b0})); // (R5)
    if (rails.rail12Low) begin
      rails.rail12Trim = `RCRB_R12_LP_TRIM; // (R4)
    end
    case (r10Sel) // (R7)
      2'h0:    rails.rail10Trim = `RCRB_R10_TRIM_C0;
      2'h1:    rails.rail10Trim = `RCRB_R10_TRIM_C1;
      2'h2:    rails.rail10Trim = `RCRB_R10_TRIM_C2;
      default: rails.rail10Trim = `RCRB_R10_TRIM_C3;
    endcase
    if (rails.rail10Low) begin
      rails.rail10Trim = `RCRB_R10_LP_BASE + 8'(signed'({5'h0, r10Lp, 1'b0})); // (R6)
    end
  end

endmodule : rcrb_trim_decode

// ---- rtl/rcrb_top.sv ----
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "rcrb_consts.svh"

// Functional notes
// (R1) Standby exit copies nonzero exit action into mode
// (R2) Switched rail off at 00, on otherwise
// (R3) Converter mode: off, auto, or forced PWM
// (R4) Rail12 low-power bit applies minus 3 percent
// (R5) Rail12 select maps eight one-percent steps
// (R6) Rail10 low-power code selects minus 4/3/2 percent
// (R7) Rail10 select maps four fixed voltages
// (R8) Rail12 register at 0x36, reset 0x3a
// (R9) Rail10 register at 0x37, reset 0x1a
// (R10) Switched register at 0x35, upper nibble read-only
// (R11) Leaving standby restores normal voltage select

module rcrb_top (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                clockEnable,
  // Avalon-MM slave
  input  wire logic [9:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  // Platform standby, low while standby is requested
  input  wire logic                standbyRequestN,
  // Rail controls
  output logic                     switchedRailOn,
  output rcrb_pkg::rcrb_mode_t     rail12Mode,
  output logic signed [7:0]        rail12Trim,
  output logic                     rail12LowPower,
  output rcrb_pkg::rcrb_mode_t     rail10Mode,
  output logic signed [7:0]        rail10Trim,
  output logic                     rail10LowPower
);
  import rcrb_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Word index from a byte address; low two bits ignored
  function automatic logic [7:0] regIndex(input logic [9:0] addr);
    regIndex = addr[9:2];
  endfunction : regIndex

  // Copies the exit-action field into the mode field unless it is 00
  function automatic logic [7:0] applyExit(input logic [7:0] regVal);
    logic [1:0] action;
    action    = regVal[`RCRB_EXIT_LSB +: 2];
    applyExit = regVal;
    if (action != 2'h0) begin
      applyExit[`RCRB_MODE_LSB +: 2] = action;
    end
  endfunction : applyExit

  // ----------------------------------------
  // State
  // ----------------------------------------
  rcrb_state_t stateQ;
  rcrb_state_t stateD;

  logic        request;
  logic        accept;
  logic        commit;
  logic        exitEdge;
  logic [7:0]  index;
  logic [7:0]  wrByte;
  logic [7:0]  rdByte;

  rcrb_rail_if rails ();

  // ----------------------------------------
  // Set-point decoder
  // ----------------------------------------
  rcrb_trim_decode rcrb_trim_decode_i (
    .rails (rails.dec)
  );

  // Decoder sees the stored registers and the live standby level
  always_comb begin
    rails.standbyActive = ~standbyRequestN;
    rails.rail12Reg     = stateQ.rail12Reg;
    rails.rail10Reg     = stateQ.rail10Reg;
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state: the request is seen, then acknowledged a cycle later.
  // A frozen clock enable keeps waitrequest high so no beat is lost.
  always_comb begin
    request     = read || write;
    accept      = request && !stateQ.ack;
    commit      = request && stateQ.ack && clockEnable;
    waitrequest = request && !commit;
    index       = regIndex(address);
    wrByte      = writedata[7:0];
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped indices read as zero; reserved switched bits stay zero
  always_comb begin
    case (index)
      `RCRB_IDX_SWITCHED: rdByte = stateQ.switchedReg; // (R10)
      `RCRB_IDX_RAIL12:   rdByte = stateQ.rail12Reg;   // (R8)
      `RCRB_IDX_RAIL10:   rdByte = stateQ.rail10Reg;   // (R9)
      default:            rdByte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Standby edge
  // ----------------------------------------
  // Rising edge of the active-low request marks standby exit
  always_comb begin
    exitEdge = standbyRequestN && !stateQ.standbyPrev; // (R1)
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    stateD             = stateQ;
    stateD.standbyPrev = standbyRequestN;
    stateD.ack         = accept;

    // Read data is captured when the request is first seen and
    // stands through the acknowledging edge
    if (accept) begin
      stateD.readData = {24'h000000, rdByte};
    end

    // A write lands only on the edge that completes the transfer;
    // an unmapped index or a cleared low byte lane drops it silently
    if (commit && write && byteenable[0]) begin
      case (index)
        `RCRB_IDX_SWITCHED: begin
          stateD.switchedReg = wrByte & `RCRB_SW_WR_MASK; // (R10)
        end
        `RCRB_IDX_RAIL12: begin
          stateD.rail12Reg = wrByte; // (R8)
        end
        `RCRB_IDX_RAIL10: begin
          stateD.rail10Reg = wrByte; // (R9)
        end
        default: begin
          stateD.readData = stateD.readData;
        end
      endcase
    end

    // Standby exit is applied after any write in the same cycle,
    // so the hardware event wins over a coincident software update
    if (exitEdge) begin
      stateD.switchedReg = applyExit(stateD.switchedReg); // (R1)
      stateD.rail12Reg   = applyExit(stateD.rail12Reg);   // (R1)
      stateD.rail10Reg   = applyExit(stateD.rail10Reg);   // (R1)
    end

    // Registered rail outputs follow the current registers
    stateD.switchedOn = (stateQ.switchedReg[`RCRB_MODE_LSB +: 2] != 2'h0); // (R2)
    stateD.rail12Mode = modeClass(stateQ.rail12Reg[`RCRB_MODE_LSB +: 2]);  // (R3)
    stateD.rail10Mode = modeClass(stateQ.rail10Reg[`RCRB_MODE_LSB +: 2]);  // (R3)

    // Set points: low-power while standby is held, normal once it ends
    stateD.rail12Trim = rails.rail12Trim; // (R4) (R5) (R11)
    stateD.rail10Trim = rails.rail10Trim; // (R6) (R7) (R11)
    stateD.rail12Low  = rails.rail12Low;  // (R4)
    stateD.rail10Low  = rails.rail10Low;  // (R6)
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset; clock enable low freezes every bit
  always_ff @(posedge clock) begin
    if (reset) begin
      stateQ.switchedReg <= `RCRB_RST_SWITCHED; // (R2) (R10)
      stateQ.rail12Reg   <= `RCRB_RST_RAIL12;   // (R3) (R5) (R8)
      stateQ.rail10Reg   <= `RCRB_RST_RAIL10;   // (R3) (R7) (R9)
      stateQ.standbyPrev <= 1'b1;
      stateQ.ack         <= 1'b0;
      stateQ.readData    <= 32'h00000000;
      stateQ.switchedOn  <= 1'b1;
      stateQ.rail12Mode  <= RCRB_MODE_AUTO;
      stateQ.rail10Mode  <= RCRB_MODE_AUTO;
      stateQ.rail12Trim  <= 8'sh00;
      stateQ.rail10Trim  <= 8'sh00;
      stateQ.rail12Low   <= 1'b0;
      stateQ.rail10Low   <= 1'b0;
    end else if (clockEnable) begin
      stateQ <= stateD;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    readdata       = stateQ.readData;
    switchedRailOn = stateQ.switchedOn;
    rail12Mode     = stateQ.rail12Mode;
    rail12Trim     = stateQ.rail12Trim;
    rail12LowPower = stateQ.rail12Low;
    rail10Mode     = stateQ.rail10Mode;
    rail10Trim     = stateQ.rail10Trim;
    rail10LowPower = stateQ.rail10Low;
  end

endmodule : rcrb_top

// ---- verif/rcrb_top_asserts.sv ----
`timescale 1ns/10ps

// ------------------------------
// Bus and rail output checks
// ------------------------------
module rcrb_top_asserts
  import rcrb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  // Register bus
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // Standby and rails
  input wire logic standbyRequestN,
  input wire logic switchedRailOn,
  input wire rcrb_pkg::rcrb_mode_t rail12Mode,
  input wire logic signed [7:0] rail12Trim,
  input wire logic rail12LowPower,
  input wire rcrb_pkg::rcrb_mode_t rail10Mode,
  input wire logic signed [7:0] rail10Trim,
  input wire logic rail10LowPower
);
  localparam logic signed [7:0] R10T [4] = '{8'sh0a, 8'sh00, 8'shfb, 8'shf6};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Expected converter class of a mode field
  function automatic rcrb_mode_t modeOf(input logic [1:0] f);
    modeOf = f == 2'h0 ? RCRB_MODE_OFF : f == 2'h3 ? RCRB_MODE_PWM : RCRB_MODE_AUTO;
  endfunction : modeOf

  // Accepted write with standby steady, so no exit copy can blur the result
  sequence wrDone(logic [9:0] a);
    write && !waitrequest && clockEnable && byteenable[0] && address == a
      && standbyRequestN && $past(standbyRequestN) ##1 clockEnable && standbyRequestN;
  endsequence

  a_one_wait: assert property ((read || write) && waitrequest && clockEnable ##1 clockEnable |-> !waitrequest)
    else $error("wait state too long");
  a_switched_decode: assert property (wrDone(10'h0d4) |=> switchedRailOn == ($past(writedata[1:0], 2) != 2'h0))
    else $error("switched rail enable wrong");
  a_mode12_decode: assert property (wrDone(10'h0d8) |=> rail12Mode == modeOf($past(writedata[1:0], 2)))
    else $error("rail12 mode wrong");
  a_mode10_decode: assert property (wrDone(10'h0dc) |=> rail10Mode == modeOf($past(writedata[1:0], 2)))
    else $error("rail10 mode wrong");
  a_trim12_decode: assert property (wrDone(10'h0d8) |=> rail12Trim == 8'(6 - 2 * int'($past(writedata[6:4], 2))))
    else $error("rail12 trim wrong");
  a_trim10_decode: assert property (wrDone(10'h0dc) |=> rail10Trim == R10T[$past(writedata[5:4], 2)])
    else $error("rail10 trim wrong");
  a_low12_trim: assert property (rail12LowPower |-> rail12Trim == 8'shfa)
    else $error("rail12 low power trim wrong");
  a_low10_trim: assert property (rail10LowPower |-> rail10Trim inside {8'shf8, 8'shfa, 8'shfc})
    else $error("rail10 low power trim wrong");
  a_standby_exit: assert property ($past(standbyRequestN, 2) && $past(standbyRequestN) && $past(clockEnable, 2)
    && $past(clockEnable) |-> !rail12LowPower && !rail10LowPower)
    else $error("low power held after standby");
  c_write12: cover property (wrDone(10'h0d8));
  c_low10: cover property (rail10LowPower);
  c_exit: cover property ($rose(standbyRequestN));
endmodule : rcrb_top_asserts

// ---- verif/rail_control_register_bank_tb_top.sv ----
`timescale 1ns/10ps

module rail_control_register_bank_tb_top;
  import rcrb_pkg::*;
  // ------------------------------
  // Signals and bookkeeping
  // ------------------------------
  logic clock = 1'b0, reset = 1'b1, clockEnable = 1'b1, read = 1'b0, write = 1'b0, standbyRequestN = 1'b1;
  logic [9:0] address = 10'h000;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [3:0] byteenable = 4'hf;
  logic waitrequest, switchedRailOn, rail12LowPower, rail10LowPower;
  rcrb_mode_t rail12Mode, rail10Mode;
  logic signed [7:0] rail12Trim, rail10Trim, e;
  logic [7:0] v;
  int badCount = 0, nCompared = 0, cycles = 0;
  localparam logic signed [7:0] R10T [4] = '{8'sh0a, 8'sh00, 8'shfb, 8'shf6};
  localparam logic signed [7:0] LP10T [4] = '{8'sh00, 8'shf8, 8'shfa, 8'shfc};

  rcrb_top rcrb_top_i (
    .clock(clock), .reset(reset), .clockEnable(clockEnable), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .standbyRequestN(standbyRequestN), .switchedRailOn(switchedRailOn), .rail12Mode(rail12Mode),
    .rail12Trim(rail12Trim), .rail12LowPower(rail12LowPower), .rail10Mode(rail10Mode),
    .rail10Trim(rail10Trim), .rail10LowPower(rail10LowPower));

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic rcrb_mode_t modeOf(input logic [1:0] f);
    modeOf = f == 2'h0 ? RCRB_MODE_OFF : f == 2'h3 ? RCRB_MODE_PWM : RCRB_MODE_AUTO;
  endfunction : modeOf

  // Waitrequest and readdata are taken at the rising edge, before that edge's updates land
  task automatic busXfer(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : busXfer

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    busXfer(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rdChk(input logic [9:0] a, input logic [31:0] exp);
    busXfer(1'b0, a, 8'h00, 4'hf);
    check("readdata", q, exp);
  endtask : rdChk

  // Rail outputs trail the register by one more edge
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic setStandby(input logic s);
    @(posedge clock);
    standbyRequestN <= s;
    settle();
  endtask : setStandby

  task automatic wrapUp();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrapUp

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic tReset();
    rdChk(10'h0d4, 32'h0a);
    rdChk(10'h0d8, 32'h3a);
    rdChk(10'h0dc, 32'h1a);
    check("railOn", switchedRailOn, 1'b1);
    check("mode12", rail12Mode, RCRB_MODE_AUTO);
    check("trim12", rail12Trim, 8'sh00);
    check("trim10", rail10Trim, 8'sh00);
  endtask : tReset

  // Read-only nibble, ignored lane, unmapped place, full-width registers
  task automatic tAccess();
    wr(10'h0d4, 8'hff);
    rdChk(10'h0d4, 32'h0f);
    wr(10'h0d4, 8'h00);
    busXfer(1'b1, 10'h0d4, 8'h03, 4'he);
    settle();
    check("railOn", switchedRailOn, 1'b0);
    rdChk(10'h0d4, 32'h00);
    rdChk(10'h3fc, 32'h00);
    wr(10'h0d8, 8'hff);
    rdChk(10'h0d8, 32'hff);
    wr(10'h0dc, 8'hff);
    rdChk(10'h0dc, 32'hff);
  endtask : tAccess

  task automatic tDecode();
    for (int c = 0; c < 8; c++) begin
      wr(10'h0d8, {1'b0, 3'(c), 2'h0, 2'(c)});
      wr(10'h0dc, {2'h0, 2'(c), 2'h0, 2'(c)});
      settle();
      e = 8'(6 - 2 * c);
      check("trim12", rail12Trim, e);
      check("mode12", rail12Mode, modeOf(2'(c)));
      check("trim10", rail10Trim, R10T[c % 4]);
      check("mode10", rail10Mode, modeOf(2'(c)));
    end
  endtask : tDecode

  // Every low-power code on entry, exit copy and restore on leaving
  task automatic tStandby();
    wr(10'h0d4, 8'h0c);
    for (int c = 0; c < 4; c++) begin
      wr(10'h0d8, {c != 0, 3'h2, 2'h3, 2'h0});
      v = {2'(c), 2'h1, 2'(c != 0), 2'h0};
      wr(10'h0dc, v);
      setStandby(1'b0);
      e = (c != 0) ? 8'shfa : 8'sh02;
      check("trim12", rail12Trim, e);
      check("low12", rail12LowPower, c != 0);
      check("trim10", rail10Trim, LP10T[c]);
      check("low10", rail10LowPower, c != 0);
      setStandby(1'b1);
      check("trim12", rail12Trim, 8'sh02);
      check("trim10", rail10Trim, 8'sh00);
      check("low12", rail12LowPower, 1'b0);
      check("mode12", rail12Mode, RCRB_MODE_PWM);
      check("mode10", rail10Mode, modeOf(2'(c != 0)));
      rdChk(10'h0dc, {24'h0, v[7:2], v[3:2]});
    end
    rdChk(10'h0d4, 32'h0f);
    check("railOn", switchedRailOn, 1'b1);
  endtask : tStandby

  // A frozen clock enable must keep the slave waiting
  task automatic tFreeze();
    @(posedge clock);
    clockEnable <= 1'b0;
    fork
      rdChk(10'h0d8, 32'haf);
      begin
        repeat (4) @(posedge clock);
        #1;
        check("wait", waitrequest, 1'b1);
        @(posedge clock);
        clockEnable <= 1'b1;
      end
    join
  endtask : tFreeze

  // Clock, hang guard and main sequence
  initial forever #10 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      wrapUp();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    tReset();
    tAccess();
    tDecode();
    tStandby();
    tFreeze();
    wrapUp();
  end
endmodule : rail_control_register_bank_tb_top

bind rcrb_top rcrb_top_asserts rcrb_top_asserts_i (
  .clock(clock), .reset(reset), .clockEnable(clockEnable), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest), .standbyRequestN(standbyRequestN),
  .switchedRailOn(switchedRailOn), .rail12Mode(rail12Mode), .rail12Trim(rail12Trim),
  .rail12LowPower(rail12LowPower), .rail10Mode(rail10Mode), .rail10Trim(rail10Trim),
  .rail10LowPower(rail10LowPower));
